// File: dps_defines.vh
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH
// ----------------------------------------------------------------------------
// Timing constants for the power sequencer, clock at 100 MHz.
// ----------------------------------------------------------------------------
`define DPS_CLK_PERIOD_NS   10
// Longest release delay with the regulator on, in microseconds.
`define DPS_LDO_DLY_US      2000
// Longest release delay with the regulator off, in nanoseconds.
`define DPS_NOLDO_DLY_NS    1000
// Longest times in whole system cycles, sized to the 18-bit counter.
`define DPS_LDO_DLY_CYC     18'h30d40
`define DPS_NOLDO_DLY_CYC   18'h00064
// Frame rises counted before a soft reset change lands on the next rise.
`define DPS_SRST_FRAMES     2'h3
// Width of the release delay counter.
`define DPS_CNT_W           18
// Sequencer state codes.
`define DPS_ST_DOWN         3'h0
`define DPS_ST_WAIT         3'h1
`define DPS_ST_CLKWAIT      3'h2
`define DPS_ST_RESET        3'h3
`define DPS_ST_RUN          3'h4
`endif

// File: dps_clk_detect.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Clock presence detector: a level is present when it toggled recently.
// ----------------------------------------------------------------------------
module dps_clk_detect (
  // System.
  input  wire clk_sys_i,
  input  wire rst_i,
  input  wire clr_i,
  // Sampled clock level.
  input  wire lvl_i,
  // Presence and rising edge.
  output reg  present_o,
  output wire rise_o
);
  // Timeout in system cycles with no edge before the clock counts as lost.
  localparam [7:0] TMO = 8'hff;

  reg       lvl_q;   // Previous sample, for edge detection.
  reg [7:0] cnt_q;   // Cycles since the last edge.

  assign rise_o = lvl_i & ~lvl_q;

  // Any edge restarts the timeout; a stopped clock drops presence.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_q     <= 1'b0;
      cnt_q     <= 8'h00;
      present_o <= 1'b0;
    end else if (clr_i) begin
      lvl_q     <= lvl_i;
      cnt_q     <= 8'h00;
      present_o <= 1'b0;
    end else begin
      lvl_q <= lvl_i;
      if (lvl_i != lvl_q) begin
        cnt_q     <= 8'h00;
        present_o <= 1'b1;
      end else if (cnt_q == TMO) begin
        present_o <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // dps_clk_detect

// File: dps_sequencer.v
// Behaviour
// - Pin low halts, initialises, outputs high-impedance.
// - Rising pin releases; outputs float until clocks.
// - Regulator on: release within 2 ms.
// - Regulator off: release within 1 us.
// - Pin mode needs port and bus select high.
// - Pin mode: power up once three clocks run.
// - Register mode: registers accessible after internal release.
// - Register mode: analogue starts with clocks, common voltage.
// - Register mode: normal only after soft reset set.
// - Soft reset changes take 3 to 4 frames.
// - Register mode power down drives flag low.
// - Soft reset bit defaults to zero.
`timescale 1ns/1ns
`include "dps_defines.vh"
module dps_sequencer #(
  parameter [17:0] LDO_DLY_CYC = `DPS_LDO_DLY_CYC
) (
  // System.
  input  wire clk_sys_i,
  input  wire rst_i,
  // Host pins.
  input  wire power_down_n_pin_i,
  input  wire regulator_enable_pin_i,
  input  wire port_select_pin_i,
  input  wire bus_select_pin_i,
  // Audio clocks, sampled as levels.
  input  wire master_clock_i,
  input  wire serial_bit_clock_i,
  input  wire frame_clock_i,
  input  wire dsd_bit_clock_i,
  input  wire dsd_mode_i,
  // Soft reset bit as written by the host, and write strobe.
  input  wire soft_reset_n_bit_i,
  input  wire soft_reset_wr_i,
  // Internal zero-detect result from the data path.
  input  wire zero_detect_i,
  // Status and control outputs.
  output reg  internal_release_o,
  output reg  regulator_on_o,
  output wire reg_access_o,
  output wire pin_mode_o,
  output reg  analog_on_o,
  output reg  outputs_hiz_o,
  output reg  outputs_common_o,
  output reg  digital_run_o,
  output reg  soft_reset_n_bit_o,
  output reg  zero_detect_flag_o,
  output reg  [2:0] state_o
);
  // --------------------------------------------------------------------------
  // Mode decode and clock presence.
  // --------------------------------------------------------------------------
  // Decode used for mode selection; pin mode only with both selects high.
  function pin_mode_f;
    input ps;
    input bs;
    begin
      pin_mode_f = ps & bs;
    end
  endfunction

  wire       pin_mode = pin_mode_f(port_select_pin_i, bus_select_pin_i);
  wire [3:0] clk_lvl  = {dsd_bit_clock_i, frame_clock_i, serial_bit_clock_i, master_clock_i};
  wire [3:0] clk_ok;     // Presence per clock.
  wire [3:0] clk_rise;   // Rising edge per clock.
  wire       pdn_low  = ~power_down_n_pin_i;

  assign pin_mode_o   = pin_mode;
  assign reg_access_o = internal_release_o & ~pin_mode;

  // Detectors are cleared in power down so they start clean.
  // Only the frame clock rise is used, to count sample periods.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_det
      dps_clk_detect u_det (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .clr_i     (pdn_low),
        .lvl_i     (clk_lvl[g]),
        .present_o (clk_ok[g]),
        .rise_o    (clk_rise[g])
      );
    end
  endgenerate

  // PCM needs master, bit and frame clocks; DSD needs master and DSD clock.
  wire pcm_clks = clk_ok[0] & clk_ok[1] & clk_ok[2];
  wire clks_ok  = pin_mode ? pcm_clks
                : (dsd_mode_i ? (clk_ok[0] & clk_ok[3]) : pcm_clks);

  // --------------------------------------------------------------------------
  // Release delay counter.
  // --------------------------------------------------------------------------
  reg         pin_q;       // Previous pin sample, to see the rising edge.
  reg  [17:0] dly_q;       // Cycles since the pin rose.
  wire [17:0] dly_lim = regulator_enable_pin_i ? LDO_DLY_CYC
                        : `DPS_NOLDO_DLY_CYC;
  reg  [2:0]  st_q;
  reg  [2:0]  st_d;
  reg  [1:0]  frm_q;       // Frame edges counted during soft reset changes.
  reg         srst_req_q;  // Soft reset value waiting to take effect.
  reg         srst_eff_q;  // Soft reset value in force.

  // The delay is timed on the always running system clock, not the audio clocks.
  // The limit is taken every cycle, so the regulator pin must stay put meanwhile.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_q              <= 1'b0;
      dly_q              <= 18'h00000;
      internal_release_o <= 1'b0;
      regulator_on_o     <= 1'b0;
    end else begin
      pin_q <= power_down_n_pin_i;
      if (pdn_low) begin
        dly_q              <= 18'h00000;
        internal_release_o <= 1'b0;
        regulator_on_o     <= 1'b0;
      end else if (~pin_q) begin
        dly_q          <= 18'h00001;
        regulator_on_o <= regulator_enable_pin_i;
      end else if (~internal_release_o) begin
        // Release one cycle early so the flag rises by the limit.
        if (dly_q >= dly_lim - 18'h00001)
          internal_release_o <= 1'b1;
        else
          dly_q <= dly_q + 18'h00001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Soft reset bit with frame-counted latency.
  // --------------------------------------------------------------------------
  // A new write restarts the count; the change lands on the fourth frame rise,
  // which falls 3 to 4 sample periods after the write. Landing on the third
  // rise would cut the delay below three periods for most clock phases.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      soft_reset_n_bit_o <= 1'b0;
      srst_req_q         <= 1'b0;
      srst_eff_q         <= 1'b0;
      frm_q              <= 2'h0;
    end else if (~internal_release_o) begin
      soft_reset_n_bit_o <= 1'b0;
      srst_req_q         <= 1'b0;
      srst_eff_q         <= 1'b0;
      frm_q              <= 2'h0;
    end else if (soft_reset_wr_i && reg_access_o) begin
      soft_reset_n_bit_o <= soft_reset_n_bit_i;
      srst_req_q         <= soft_reset_n_bit_i;
      frm_q              <= 2'h0;
    end else if (srst_req_q != srst_eff_q && clk_rise[2]) begin
      if (frm_q == `DPS_SRST_FRAMES)
        srst_eff_q <= srst_req_q;
      else
        frm_q <= frm_q + 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer state machine.
  // --------------------------------------------------------------------------
  // Next state: wait release, wait clocks, then reset or run.
  always @* begin
    st_d = st_q;
    case (st_q)
      `DPS_ST_DOWN:    st_d = `DPS_ST_WAIT;
      `DPS_ST_WAIT:    if (internal_release_o) st_d = `DPS_ST_CLKWAIT;
      `DPS_ST_CLKWAIT: if (clks_ok) st_d = pin_mode ? `DPS_ST_RUN : `DPS_ST_RESET;
      `DPS_ST_RESET: begin
        if (!clks_ok) st_d = `DPS_ST_CLKWAIT;
        else if (srst_eff_q) st_d = `DPS_ST_RUN;
      end
      `DPS_ST_RUN: begin
        if (!clks_ok) st_d = `DPS_ST_CLKWAIT;
        else if (!pin_mode && !srst_eff_q) st_d = `DPS_ST_RESET;
      end
      default:         st_d = `DPS_ST_DOWN;
    endcase
    if (pdn_low) st_d = `DPS_ST_DOWN;
  end

  // State register; the asynchronous reset parks the machine in power down.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) st_q <= `DPS_ST_DOWN;
    else       st_q <= st_d;
  end

  // --------------------------------------------------------------------------
  // Registered outputs.
  // --------------------------------------------------------------------------
  // Outputs float in every state before the analogue section runs.
  // Each output is decoded from the next state so it moves with the state.
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      analog_on_o        <= 1'b0;
      outputs_hiz_o      <= 1'b1;
      outputs_common_o   <= 1'b0;
      digital_run_o      <= 1'b0;
      zero_detect_flag_o <= 1'b0;
      state_o            <= `DPS_ST_DOWN;
    end else begin
      state_o          <= st_d;
      analog_on_o      <= (st_d == `DPS_ST_RESET) || (st_d == `DPS_ST_RUN);
      outputs_hiz_o    <= (st_d != `DPS_ST_RESET) && (st_d != `DPS_ST_RUN);
      outputs_common_o <= (st_d == `DPS_ST_RESET);
      digital_run_o    <= (st_d == `DPS_ST_RUN);
      // Flag is low in power down, high while held in soft reset.
      if (st_d == `DPS_ST_DOWN || st_d == `DPS_ST_WAIT)
        zero_detect_flag_o <= 1'b0;
      else if (st_d == `DPS_ST_RESET)
        zero_detect_flag_o <= 1'b1;
      else
        zero_detect_flag_o <= zero_detect_i & (st_d == `DPS_ST_RUN);
    end
  end
endmodule // dps_sequencer

// File: dps_chk.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Port checker for the power sequencer.
// ----------------------------------------------------------------------------
module dps_chk #(parameter [17:0] LDO_DLY_CYC = 18'h30d40) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire power_down_n_pin_i,
  input wire regulator_enable_pin_i,
  input wire port_select_pin_i,
  input wire bus_select_pin_i,
  input wire internal_release_o,
  input wire reg_access_o,
  input wire pin_mode_o,
  input wire analog_on_o,
  input wire outputs_hiz_o,
  input wire outputs_common_o,
  input wire digital_run_o,
  input wire soft_reset_n_bit_o,
  input wire zero_detect_flag_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Cycles spent with the pin high and no release yet.
  logic [17:0] wait_q;
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) wait_q <= 18'h0;
    else if (!power_down_n_pin_i || internal_release_o) wait_q <= 18'h0;
    else wait_q <= wait_q + 18'h1;
  property p_pdn_hold; !power_down_n_pin_i ##1 !power_down_n_pin_i
    |-> outputs_hiz_o && !internal_release_o && !analog_on_o; endproperty
  a_pdn_hold: assert property (p_pdn_hold) else $error("pin low not halting");
  property p_rel_lim;
    wait_q <= (regulator_enable_pin_i ? LDO_DLY_CYC + 18'h1 : 18'h65); endproperty
  a_rel_lim: assert property (p_rel_lim) else $error("release late");
  property p_hiz; (!analog_on_o || !internal_release_o) |-> outputs_hiz_o; endproperty
  a_hiz: assert property (p_hiz) else $error("outputs driven while off");
  property p_mode; pin_mode_o == (port_select_pin_i && bus_select_pin_i); endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_acc; reg_access_o == (internal_release_o && !pin_mode_o); endproperty
  a_acc: assert property (p_acc) else $error("access gate wrong");
  property p_com; outputs_common_o |-> analog_on_o && !outputs_hiz_o && !digital_run_o; endproperty
  a_com: assert property (p_com) else $error("common level state wrong");
  property p_run; $rose(digital_run_o) && !pin_mode_o |-> soft_reset_n_bit_o; endproperty
  a_run: assert property (p_run) else $error("run without soft reset");
  property p_zf; !power_down_n_pin_i ##1 !power_down_n_pin_i |-> !zero_detect_flag_o; endproperty
  a_zf: assert property (p_zf) else $error("flag high when down");
  property p_def; $rose(internal_release_o) |-> !soft_reset_n_bit_o; endproperty
  a_def: assert property (p_def) else $error("soft reset not default");
endmodule // dps_chk
bind dps_sequencer dps_chk #(.LDO_DLY_CYC(LDO_DLY_CYC)) dps_chk_i (.*);

// File: dps_host.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Host clock source; clocks stand still low while stopped.
// ----------------------------------------------------------------------------
module dps_host (
  input  wire  clk_sys_i,
  input  wire  run_i,
  input  wire  fr_en_i,
  output logic mclk_o,
  output logic bclk_o,
  output logic fclk_o
);
  logic [5:0] div_q = 6'h00;
  always @(posedge clk_sys_i) div_q <= run_i ? div_q + 6'h01 : 6'h00;
  assign mclk_o = div_q[0];
  assign bclk_o = div_q[1];
  assign fclk_o = div_q[5] & fr_en_i; // One frame every 64 cycles; held low when off.
endmodule // dps_host

// File: dps_sequencer_bench.sv
`timescale 1ns/1ns
`include "dps_defines.vh"
// ----------------------------------------------------------------------------
// Bench for the power sequencer: pin pulses, soft reset writes, clock sets.
// ----------------------------------------------------------------------------
module dps_sequencer_bench;
  logic clk_sys_i = 0, rst_i = 1, power_down_n_pin = 0, regen = 0, ps = 0, bs = 1;
  logic srst = 0, wr = 0, run = 0, dsd = 0, fen = 1;
  wire mclk, bclk, fclk, rel, acc, pmode, aon, hiz, com, drun, srst_o, zf, regon;
  wire [2:0] state;
  int n_fail = 0, n_tests = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  dps_host dps_host_i (.clk_sys_i(clk_sys_i), .run_i(run), .fr_en_i(fen), .mclk_o(mclk), .bclk_o(bclk),
    .fclk_o(fclk));
  dps_sequencer #(.LDO_DLY_CYC(18'h32)) dps_sequencer_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .power_down_n_pin_i(power_down_n_pin), .regulator_enable_pin_i(regen),
    .port_select_pin_i(ps), .bus_select_pin_i(bs), .master_clock_i(mclk), .serial_bit_clock_i(bclk),
    .frame_clock_i(fclk), .dsd_bit_clock_i(bclk), .dsd_mode_i(dsd), .soft_reset_n_bit_i(srst),
    .soft_reset_wr_i(wr), .zero_detect_i(1'b1), .internal_release_o(rel), .regulator_on_o(regon),
    .reg_access_o(acc), .pin_mode_o(pmode), .analog_on_o(aon), .outputs_hiz_o(hiz),
    .outputs_common_o(com), .digital_run_o(drun), .soft_reset_n_bit_o(srst_o),
    .zero_detect_flag_o(zf), .state_o(state));
  task chk(input logic [2:0] s, input logic [2:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // A write is a one-cycle strobe with the bit value beside it.
  task wr_srst(input logic v);
    srst = v;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask
  // Pulse the pin low, release it and time the internal release.
  task power_up(input logic le, input logic p, input int lim);
    int n;
    n = 0;
    run = 0;
    power_down_n_pin = 0;
    regen = le;
    ps = p;
    cyc(20);
    chk(hiz, 1);
    chk(rel, 0);
    chk(zf, 0);
    chk(state, `DPS_ST_DOWN);
    wr_srst(1);
    chk(srst_o, 0);
    power_down_n_pin = 1;
    while (rel !== 1'b1 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk(n <= lim, 1);
    chk(regon, le);
    chk(srst_o, 0);
    chk(acc, !p);
    chk(hiz, 1);
    run = 1;
    cyc(600);
  endtask
  task close_out;
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(8);
    rst_i = 0;
    for (int i = 0; i < 4; i++) begin
      {ps, bs} = i[1:0];
      cyc(1);
      chk(pmode, i == 3);
    end
    power_up(0, 0, 100);
    chk(com, 1);
    chk(hiz, 0);
    chk(aon, 1);
    chk(drun, 0);
    chk(zf, 1);
    chk(state, `DPS_ST_RESET);
    // A soft reset change must not land before three frames nor after four.
    wr_srst(1);
    cyc(192);
    chk(drun, 0);
    cyc(66);
    chk(drun, 1);
    chk(state, `DPS_ST_RUN);
    wr_srst(0);
    cyc(192);
    chk(drun, 1);
    cyc(66);
    chk(drun, 0);
    run = 0;
    cyc(300);
    chk(hiz, 1);
    chk(state, `DPS_ST_CLKWAIT);
    // DSD set: master and DSD bit clock suffice, the frame clock stays off.
    dsd = 1;
    fen = 0;
    run = 1;
    cyc(100);
    chk(com, 1);
    chk(state, `DPS_ST_RESET);
    // Back to the PCM set without a frame clock: outputs must float again.
    dsd = 0;
    cyc(4);
    chk(hiz, 1);
    fen = 1;
    power_up(1, 1, 50);
    chk(drun, 1);
    chk(aon, 1);
    chk(hiz, 0);
    chk(state, `DPS_ST_RUN);
    close_out;
  end
  initial begin
    cyc(20000);
    n_fail++;
    close_out;
  end
endmodule // dps_sequencer_bench
